/* File: pcicfg_map.svh */
// pcicfg_map.svh: offsets, field positions, fixed field values and reset values
// for the configuration command/status block; included by bare name.
`ifndef PCICFG_MAP_SVH
`define PCICFG_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets (dword aligned)
// ---------------------------------------------------------------
`define PCICFG_OFS_CMD_STAT  8'h04
`define PCICFG_OFS_REV_CLASS 8'h08
`define PCICFG_OFS_CLS_LAT   8'h0c

// ---------------------------------------------------------------
// command halfword bit positions
// ---------------------------------------------------------------
`define PCICFG_CMD_MEM_SPACE   1
`define PCICFG_CMD_BUS_MASTER  2
`define PCICFG_CMD_PARITY_RESP 6
`define PCICFG_CMD_SERR_EN     8

// ---------------------------------------------------------------
// status bit positions within the command/status dword
// ---------------------------------------------------------------
`define PCICFG_ST_FB2B_TARGET  23
`define PCICFG_ST_MASTER_PERR  24
`define PCICFG_ST_SEL_LOW      25
`define PCICFG_ST_SEL_HIGH     26
`define PCICFG_ST_TARGET_ABORT_SIGNALLED_RX      28
`define PCICFG_ST_MASTER_ABORT_RECEIVED_RX      29
`define PCICFG_ST_SERR_SIG     30
`define PCICFG_ST_PERR_DET     31

// ---------------------------------------------------------------
// constant field values
// ---------------------------------------------------------------
`define PCICFG_SEL_TIMING    2'h1
`define PCICFG_CLASS_IF      8'h00
`define PCICFG_CLASS_SUB     8'h80
`define PCICFG_CLASS_BASE    8'h02
`define PCICFG_HEADER_TYPE   8'h80
`define PCICFG_SELF_TEST     8'h00

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PCICFG_RST_CMD       16'h0000
`define PCICFG_RST_FLAGS     5'h00
`define PCICFG_RST_CLS       8'h00
`define PCICFG_RST_LAT       8'h00

// ---------------------------------------------------------------
// honoured cache line sizes (dwords)
// ---------------------------------------------------------------
`define PCICFG_CLS_4         8'h04
`define PCICFG_CLS_8         8'h08
`define PCICFG_CLS_16        8'h10
`define PCICFG_CLS_32        8'h20
`define PCICFG_CLS_64        8'h40

`endif

/* File: pcicfg_pkg.sv */
// pcicfg_pkg.sv: types shared by the configuration command/status block.
// assumes pcicfg_map.svh holds every number.
package pcicfg_pkg;

  // status flags kept by the flag bank, in this index order
  typedef enum logic [2:0] {
    FLG_MASTER_PERR = 3'h0,
    FLG_TARGET_ABORT_SIGNALLED_RX     = 3'h1,
    FLG_MASTER_ABORT_RECEIVED_RX     = 3'h2,
    FLG_SERR_SIG    = 3'h3,
    FLG_PERR_DET    = 3'h4
  } pcicfg_flag_t;

  // target claim sequencer, one-hot
  typedef enum logic [2:0] {
    CLM_IDLE  = 3'h1,
    CLM_WAIT  = 3'h2,
    CLM_CLAIM = 3'h4
  } pcicfg_claim_t;

endpackage

/* File: pcicfg_flag_if.sv */
// pcicfg_flag_if.sv: carries set and clear strobes to the sticky flag bank
// and the flag levels back. assumes one clock domain.
`timescale 1ns/10ps
interface pcicfg_flag_if;
  logic [4:0] flagSet;
  logic [4:0] flagClr;
  logic [4:0] flags;
  modport owner (output flagSet, output flagClr, input flags);
  modport bank  (input flagSet, input flagClr, output flags);
endinterface

/* File: pcicfg_flag_bank.sv */
// pcicfg_flag_bank.sv: write-one-to-clear sticky status flags.
// assumes set/clear strobes come from logic on clk_sys.
`timescale 1ns/10ps
`include "pcicfg_map.svh"
module pcicfg_flag_bank (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rstSync_n,
  // flag strobes and levels
  pcicfg_flag_if.bank    fl
);

  logic [4:0] flag_ff;
  logic [4:0] nxt_flag;

  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_flag
      // a set in the clearing cycle wins so no event is lost
      assign nxt_flag[i] = fl.flagSet[i] | (flag_ff[i] & ~fl.flagClr[i]);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      flag_ff <= `PCICFG_RST_FLAGS;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign fl.flags = flag_ff;

endmodule

/* File: pcicfg_regs.sv */
// pcicfg_regs.sv: command/status, revision/class and cache line/latency
// configuration registers of one function, plus the controls they drive.
// assumes a target front end on clk_sys turns configuration cycles into
// one-cycle read/write strobes and reports bus events as one-cycle pulses.
`timescale 1ns/10ps
`include "pcicfg_map.svh"

module pcicfg_regs #(
  // arbitrary value, not a real revision code
  parameter logic [7:0] REVISION_CODE = 8'h3c
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // configuration access
  input  wire logic       cfgRead,
  input  wire logic       cfgWrite,
  input  wire logic [7:0] cfgAddr,
  input  wire logic [3:0] cfgByteEn,
  input  wire logic [31:0] cfgWrData,
  output logic      [31:0] cfgRdData,
  output logic            cfgRdValid,
  // bus events from the transaction logic
  input  wire logic       masterParityEvent,
  input  wire logic       targetAbortSeen,
  input  wire logic       masterAbortSeen,
  input  wire logic       specialCycle,
  input  wire logic       sysErrCondition,
  input  wire logic       parityErrSeen,
  // target claim
  input  wire logic       memAddrHit,
  input  wire logic       ioAddrHit,
  input  wire logic       targetDone,
  output logic            deviceSelect_n,
  // system error pin (open drain)
  output logic            systemErrorOut_n,
  output logic            systemErrorOutEn,
  // master side controls
  input  wire logic [7:0] masterReadBurst,
  output logic            readMultiple,
  output logic            masterAllowed,
  output logic            parityRespond,
  output logic      [7:0] latencyTimer
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstMeta_ff;
  logic rstSync_n;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_n  <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_n  <= rstMeta_ff;
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // offsets are kept as full bytes so only their dword index is compared;
  // the two low address bits never select anything in a dword access
  wire [7:0] ofsCmd   = `PCICFG_OFS_CMD_STAT;
  wire [7:0] ofsRev   = `PCICFG_OFS_REV_CLASS;
  wire [7:0] ofsCls   = `PCICFG_OFS_CLS_LAT;
  wire [5:0] cfgDword = cfgAddr[7:2];

  wire hitCmd   = (cfgDword == ofsCmd[7:2]);
  wire hitRev   = (cfgDword == ofsRev[7:2]);
  wire hitCls   = (cfgDword == ofsCls[7:2]);
  wire wrCmd    = cfgWrite & hitCmd;
  wire wrCls    = cfgWrite & hitCls;

  // ---------------------------------------------------------------
  // command halfword
  // ---------------------------------------------------------------
  logic memSpace_ff;
  logic busMaster_ff;
  logic parityResp_ff;
  logic serrEn_ff;

  wire nxt_memSpace   = (wrCmd & cfgByteEn[0]) ?
                        cfgWrData[`PCICFG_CMD_MEM_SPACE] : memSpace_ff;
  wire nxt_busMaster  = (wrCmd & cfgByteEn[0]) ?
                        cfgWrData[`PCICFG_CMD_BUS_MASTER] : busMaster_ff;
  wire nxt_parityResp = (wrCmd & cfgByteEn[0]) ?
                        cfgWrData[`PCICFG_CMD_PARITY_RESP] : parityResp_ff;
  wire nxt_serrEn     = (wrCmd & cfgByteEn[1]) ?
                        cfgWrData[`PCICFG_CMD_SERR_EN] : serrEn_ff;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      memSpace_ff   <= 1'b0;
      busMaster_ff  <= 1'b0;
      parityResp_ff <= 1'b0;
      serrEn_ff     <= 1'b0;
    end else begin
      memSpace_ff   <= nxt_memSpace;
      busMaster_ff  <= nxt_busMaster;
      parityResp_ff <= nxt_parityResp;
      serrEn_ff     <= nxt_serrEn;
    end
  end

  // fixed-zero positions are never stored, so no write can set them
  logic [15:0] cmdWord;
  always_comb begin
    cmdWord                          = `PCICFG_RST_CMD;
    cmdWord[`PCICFG_CMD_MEM_SPACE]   = memSpace_ff;
    cmdWord[`PCICFG_CMD_BUS_MASTER]  = busMaster_ff;
    cmdWord[`PCICFG_CMD_PARITY_RESP] = parityResp_ff;
    cmdWord[`PCICFG_CMD_SERR_EN]     = serrEn_ff;
  end

  // only configuration access survives an all-zero command word
  wire disconnected = (cmdWord == 16'h0000);

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  pcicfg_flag_if flagBus ();

  wire [4:0] clrMask = {cfgWrData[`PCICFG_ST_PERR_DET],
                        cfgWrData[`PCICFG_ST_SERR_SIG],
                        cfgWrData[`PCICFG_ST_MASTER_ABORT_RECEIVED_RX],
                        cfgWrData[`PCICFG_ST_TARGET_ABORT_SIGNALLED_RX],
                        cfgWrData[`PCICFG_ST_MASTER_PERR]};
  // all five flags live in bits 31:24, so only byte lane 3 can clear them
  wire       clrLane = wrCmd & cfgByteEn[3];

  assign flagBus.flagClr = clrLane ? clrMask : 5'h00;
  assign flagBus.flagSet[pcicfg_pkg::FLG_MASTER_PERR] =
         masterParityEvent & parityResp_ff;
  assign flagBus.flagSet[pcicfg_pkg::FLG_TARGET_ABORT_SIGNALLED_RX] = targetAbortSeen;
  assign flagBus.flagSet[pcicfg_pkg::FLG_MASTER_ABORT_RECEIVED_RX] =
         masterAbortSeen & ~specialCycle;
  assign flagBus.flagSet[pcicfg_pkg::FLG_SERR_SIG] = sysErrCondition;
  assign flagBus.flagSet[pcicfg_pkg::FLG_PERR_DET] = parityErrSeen;

  pcicfg_flag_bank u_flags (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .fl        (flagBus.bank)
  );

  logic [15:0] statWord;
  always_comb begin
    statWord = 16'h0000;
    statWord[`PCICFG_ST_FB2B_TARGET - 16] = 1'b1;
    statWord[`PCICFG_ST_SEL_HIGH - 16 : `PCICFG_ST_SEL_LOW - 16] =
      `PCICFG_SEL_TIMING;
    statWord[`PCICFG_ST_MASTER_PERR - 16] =
      flagBus.flags[pcicfg_pkg::FLG_MASTER_PERR];
    statWord[`PCICFG_ST_TARGET_ABORT_SIGNALLED_RX - 16] = flagBus.flags[pcicfg_pkg::FLG_TARGET_ABORT_SIGNALLED_RX];
    statWord[`PCICFG_ST_MASTER_ABORT_RECEIVED_RX - 16] = flagBus.flags[pcicfg_pkg::FLG_MASTER_ABORT_RECEIVED_RX];
    statWord[`PCICFG_ST_SERR_SIG - 16] = flagBus.flags[pcicfg_pkg::FLG_SERR_SIG];
    statWord[`PCICFG_ST_PERR_DET - 16] = flagBus.flags[pcicfg_pkg::FLG_PERR_DET];
  end

  // ---------------------------------------------------------------
  // cache line size and latency timer
  // ---------------------------------------------------------------
  logic [7:0] cacheLine_ff;
  logic [7:0] latency_ff;

  wire [7:0] nxt_cacheLine = (wrCls & cfgByteEn[0]) ? cfgWrData[7:0] : cacheLine_ff;
  wire [7:0] nxt_latency   = (wrCls & cfgByteEn[1]) ? cfgWrData[15:8] : latency_ff;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cacheLine_ff <= `PCICFG_RST_CLS;
      latency_ff   <= `PCICFG_RST_LAT;
    end else begin
      cacheLine_ff <= nxt_cacheLine;
      latency_ff   <= nxt_latency;
    end
  end

  // the stored value reads back as written; only its use is filtered
  wire clsHonoured = (cacheLine_ff == `PCICFG_CLS_4)  ||
                     (cacheLine_ff == `PCICFG_CLS_8)  ||
                     (cacheLine_ff == `PCICFG_CLS_16) ||
                     (cacheLine_ff == `PCICFG_CLS_32) ||
                     (cacheLine_ff == `PCICFG_CLS_64);
  wire [7:0] clsEffective = clsHonoured ? cacheLine_ff : 8'h00;

  // an unset line size means plain reads, never read multiple
  wire nxt_readMultiple = (clsEffective != 8'h00) &&
                          (masterReadBurst > clsEffective);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [31:0] revWord = {`PCICFG_CLASS_BASE, `PCICFG_CLASS_SUB,
                         `PCICFG_CLASS_IF, REVISION_CODE};
  wire [31:0] clsWord = {`PCICFG_SELF_TEST, `PCICFG_HEADER_TYPE,
                         latency_ff, cacheLine_ff};

  // unmapped offsets read zero
  wire [31:0] nxt_rdData = hitCmd ? {statWord, cmdWord} :
                           hitRev ? revWord :
                           hitCls ? clsWord : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgRead;
    end
  end

  // data holds between reads so a slow host may sample it late
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfgRdData <= 32'h0000_0000;
    end else if (cfgRead) begin
      cfgRdData <= nxt_rdData;
    end
  end

  // ---------------------------------------------------------------
  // target claim, medium select timing
  // ---------------------------------------------------------------
  pcicfg_pkg::pcicfg_claim_t claim_ff;
  pcicfg_pkg::pcicfg_claim_t nxt_claim;

  // io hits are deliberately not looked at: io space is never claimed
  wire claimStart = memAddrHit & memSpace_ff & ~disconnected;

  always_comb begin
    case (claim_ff)
      pcicfg_pkg::CLM_IDLE: begin
        nxt_claim = claimStart ? pcicfg_pkg::CLM_WAIT : pcicfg_pkg::CLM_IDLE;
      end
      pcicfg_pkg::CLM_WAIT: begin
        nxt_claim = pcicfg_pkg::CLM_CLAIM;
      end
      pcicfg_pkg::CLM_CLAIM: begin
        nxt_claim = targetDone ? pcicfg_pkg::CLM_IDLE : pcicfg_pkg::CLM_CLAIM;
      end
      default: begin
        nxt_claim = pcicfg_pkg::CLM_IDLE;
      end
    endcase
  end

  // io hits end here on purpose: nothing downstream may claim them
  wire unusedIo  = ioAddrHit;
  wire claimNext = (nxt_claim == pcicfg_pkg::CLM_CLAIM);

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      claim_ff <= pcicfg_pkg::CLM_IDLE;
    end else begin
      claim_ff <= nxt_claim;
    end
  end

  // taken from the next state so the pin leaves a flop without extra lag
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      deviceSelect_n <= 1'b1;
    end else begin
      deviceSelect_n <= ~claimNext;
    end
  end

  // ---------------------------------------------------------------
  // registered controls and system error pin
  // ---------------------------------------------------------------
  wire serrDrive = sysErrCondition & serrEn_ff;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      readMultiple <= 1'b0;
    end else begin
      readMultiple <= nxt_readMultiple;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      masterAllowed <= 1'b0;
    end else begin
      masterAllowed <= busMaster_ff & ~disconnected;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      parityRespond <= 1'b0;
      latencyTimer  <= `PCICFG_RST_LAT;
    end else begin
      parityRespond <= parityResp_ff;
      latencyTimer  <= latency_ff;
    end
  end

  // open drain: only ever pulls low, and only while enabled
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      systemErrorOut_n <= 1'b1;
      systemErrorOutEn <= 1'b0;
    end else begin
      systemErrorOut_n <= ~serrDrive;
      systemErrorOutEn <= serrDrive;
    end
  end

endmodule

/* File: pcicfg_regs_monitor.sv */
// pcicfg_regs_monitor.sv: port-level checks for pcicfg_regs.
// assumes one clock domain; bound to the top module from the bench.
`timescale 1ns/10ps
module pcicfg_regs_monitor (
  // clock and reset
  input wire logic        clk_sys, reset_n,
  // configuration access
  input wire logic        cfgRead, cfgWrite,
  input wire logic [7:0]  cfgAddr,
  input wire logic [3:0]  cfgByteEn,
  input wire logic [31:0] cfgWrData, cfgRdData,
  input wire logic        cfgRdValid,
  // bus events
  input wire logic        masterParityEvent, targetAbortSeen, masterAbortSeen,
  input wire logic        specialCycle, sysErrCondition, parityErrSeen,
  // claim, pin and master controls
  input wire logic        memAddrHit, ioAddrHit, targetDone, deviceSelect_n,
  input wire logic        systemErrorOut_n, systemErrorOutEn,
  input wire logic [7:0]  masterReadBurst, latencyTimer,
  input wire logic        readMultiple, masterAllowed, parityRespond
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire cmdSel = cfgAddr[7:2] == 6'h01;
  wire rdCmd  = cfgRead && cmdSel;
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_seen_read(ev);
    ev ##1 rdCmd;
  endsequence
  sequence s_master_on;
    cfgWrite && cmdSel && cfgByteEn[0] && cfgWrData[2] ##1 !(cfgWrite && cmdSel);
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_rd_valid; cfgRead |=> cfgRdValid; endproperty
  property p_cmd_ro;
    rdCmd |=> cfgRdData[0] == 1'b0 && cfgRdData[5:3] == 3'h0 && cfgRdData[7] == 1'b0
              && cfgRdData[15:9] == 7'h00;
  endproperty
  property p_stat_fixed;
    rdCmd |=> cfgRdData[23:16] == 8'h80 && cfgRdData[27:25] == 3'h1;
  endproperty
  property p_rev_class;
    cfgRead && cfgAddr[7:2] == 6'h02 |=> cfgRdData[31:8] == 24'h028000;
  endproperty
  property p_header;
    cfgRead && cfgAddr[7:2] == 6'h03 |=> cfgRdData[31:16] == 16'h0080;
  endproperty
  property p_target_abort_signalled_flag; s_seen_read(targetAbortSeen) |=> cfgRdData[28]; endproperty
  property p_perr_flag; s_seen_read(parityErrSeen) |=> cfgRdData[31]; endproperty
  property p_serr_flag; s_seen_read(sysErrCondition) |=> cfgRdData[30]; endproperty
  property p_master; s_master_on |=> masterAllowed; endproperty
  property p_serr_pin;
    systemErrorOutEn |-> !systemErrorOut_n && $past(sysErrCondition);
  endproperty
  property p_claim; $fell(deviceSelect_n) |-> $past(memAddrHit, 2); endproperty
  property p_plain_read; masterReadBurst == 8'h00 |=> !readMultiple; endproperty
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_rd_valid: assert property (p_rd_valid) else $error("read gave no valid");
  a_cmd_ro: assert property (p_cmd_ro) else $error("command fixed bits");
  a_stat_fixed: assert property (p_stat_fixed) else $error("status fixed bits");
  a_rev_class: assert property (p_rev_class) else $error("class code");
  a_header: assert property (p_header) else $error("header or self-test");
  a_target_abort_signalled_flag: assert property (p_target_abort_signalled_flag) else $error("abort flag");
  a_perr_flag: assert property (p_perr_flag) else $error("parity flag");
  a_serr_flag: assert property (p_serr_flag) else $error("system error flag");
  a_master: assert property (p_master) else $error("master not allowed");
  a_serr_pin: assert property (p_serr_pin) else $error("error pin");
  a_claim: assert property (p_claim) else $error("claim timing");
  a_plain_read: assert property (p_plain_read) else $error("read multiple");
endmodule

/* File: pcicfg_host_model.sv */
// pcicfg_host_model.sv: host issuing configuration cycles as strobes.
// assumes every task is entered at a falling edge and returns at one.
`timescale 1ns/10ps
module pcicfg_host_model (
  // clock
  input  wire logic        clk_sys,
  // configuration access
  output logic             cfgRead,
  output logic             cfgWrite,
  output logic [7:0]       cfgAddr,
  output logic [3:0]       cfgByteEn,
  output logic [31:0]      cfgWrData,
  input  wire logic [31:0] cfgRdData,
  input  wire logic        cfgRdValid
);
  initial begin
    cfgRead   = 1'b0;
    cfgWrite  = 1'b0;
    cfgAddr   = 8'h00;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h0;
  end
  // idle lines flip so nothing can lean on a stale address or data
  task automatic idle_bus();
    cfgRead   = 1'b0;
    cfgWrite  = 1'b0;
    cfgAddr   = ~cfgAddr;
    cfgByteEn = ~cfgByteEn;
    cfgWrData = ~cfgWrData;
    @(negedge clk_sys);
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfgWrite  = 1'b1;
    cfgAddr   = a;
    cfgByteEn = be;
    cfgWrData = d;
    @(negedge clk_sys);
    idle_bus();
  endtask
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic v);
    cfgRead = 1'b1;
    cfgAddr = a;
    @(negedge clk_sys);
    v = cfgRdValid;
    d = cfgRdData;
    idle_bus();
  endtask
endmodule

/* File: tb_pcicfg_regs.sv */
// tb_pcicfg_regs.sv: self-checking bench for pcicfg_regs.
// assumes the host model for configuration cycles; all inputs change on falling edges.
`timescale 1ns/10ps
module tb_pcicfg_regs;
  typedef struct {logic [7:0] a; logic [3:0] be; logic [31:0] wd, exp;} pcicfg_row_t;
  logic clk_sys, reset_n, specialCycle, cfgRead, cfgWrite, cfgRdValid;
  logic deviceSelect_n, systemErrorOut_n, systemErrorOutEn;
  logic readMultiple, masterAllowed, parityRespond;
  logic [7:0] cfgAddr, masterReadBurst, latencyTimer, evt;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData;
  int failures = 0, check_count = 0, cycles = 0;
  pcicfg_row_t rows [7];
  // arbitrary revision code
  pcicfg_regs #(.REVISION_CODE(8'h5a)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .masterParityEvent(evt[0]),
    .targetAbortSeen(evt[1]), .masterAbortSeen(evt[2]), .specialCycle(specialCycle),
    .sysErrCondition(evt[3]), .parityErrSeen(evt[4]), .memAddrHit(evt[5]),
    .ioAddrHit(evt[6]), .targetDone(evt[7]), .deviceSelect_n(deviceSelect_n),
    .systemErrorOut_n(systemErrorOut_n), .systemErrorOutEn(systemErrorOutEn),
    .masterReadBurst(masterReadBurst), .readMultiple(readMultiple),
    .masterAllowed(masterAllowed), .parityRespond(parityRespond),
    .latencyTimer(latencyTimer));
  pcicfg_host_model host (
    .clk_sys(clk_sys), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    host.cfg_read(a, d, v);
    check(32'(v), 32'h1);
    check(d, exp);
  endtask
  task automatic pulse(input logic [7:0] v);
    evt = v;
    @(negedge clk_sys);
    evt = 8'h00;
  endtask
  task automatic wait_edges(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    wait_edges(12);
    reset_n = 1'b1;
    wait_edges(3);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    evt = 8'h00;
    specialCycle = 1'b0;
    masterReadBurst = 8'h00;
    rows = '{'{8'h04, 4'hf, 32'hffffffff, 32'h02800146},
             '{8'h04, 4'h1, 32'h00000000, 32'h02800100},
             '{8'h08, 4'hf, 32'hffffffff, 32'h0280005a},
             '{8'h0c, 4'hf, 32'hffffffff, 32'h0080ffff},
             '{8'h0c, 4'h2, 32'h00001200, 32'h008012ff},
             '{8'h0c, 4'h1, 32'h00000020, 32'h00801220},
             '{8'h40, 4'hf, 32'hffffffff, 32'h00000000}};
    do_reset();
    foreach (rows[i]) begin
      host.cfg_write(rows[i].a, rows[i].be, rows[i].wd);
      rd_chk(rows[i].a, rows[i].exp);
    end
    check(32'(latencyTimer), 32'h12);
    $display("table done");
    masterReadBurst = 8'h21;
    wait_edges(1);
    check(32'(readMultiple), 32'h1);
    masterReadBurst = 8'h20;
    wait_edges(1);
    check(32'(readMultiple), 32'h0);
    host.cfg_write(8'h0c, 4'h1, 32'h00000030);
    masterReadBurst = 8'h21;
    wait_edges(1);
    check(32'(readMultiple), 32'h0);
    $display("cache line done");
    host.cfg_write(8'h04, 4'h1, 32'h00000040);
    check(32'(parityRespond), 32'h1);
    pulse(8'h1f);
    rd_chk(8'h04, 32'hf3800140);
    host.cfg_write(8'h04, 4'h8, 32'h10000000);
    rd_chk(8'h04, 32'he3800140);
    host.cfg_write(8'h04, 4'h8, 32'hff000000);
    host.cfg_write(8'h04, 4'h1, 32'h00000000);
    specialCycle = 1'b1;
    pulse(8'h15);
    specialCycle = 1'b0;
    rd_chk(8'h04, 32'h82800100);
    pulse(8'h08);
    check({30'h0, systemErrorOutEn, systemErrorOut_n}, 32'h2);
    host.cfg_write(8'h04, 4'h2, 32'h00000000);
    pulse(8'h08);
    check({30'h0, systemErrorOutEn, systemErrorOut_n}, 32'h1);
    rd_chk(8'h04, 32'hc2800000);
    $display("status done");
    pulse(8'h20);
    wait_edges(2);
    check(32'(deviceSelect_n), 32'h1);
    host.cfg_write(8'h04, 4'h1, 32'h00000004);
    pulse(8'h20);
    wait_edges(2);
    check(32'(deviceSelect_n), 32'h1);
    check(32'(masterAllowed), 32'h1);
    host.cfg_write(8'h04, 4'h1, 32'h00000002);
    check(32'(masterAllowed), 32'h0);
    pulse(8'h40);
    wait_edges(2);
    check(32'(deviceSelect_n), 32'h1);
    pulse(8'h20);
    wait_edges(2);
    check(32'(deviceSelect_n), 32'h0);
    pulse(8'h80);
    wait_edges(1);
    check(32'(deviceSelect_n), 32'h1);
    $display("claim done");
    do_reset();
    rd_chk(8'h04, 32'h02800000);
    rd_chk(8'h0c, 32'h00800000);
    check({24'h0, latencyTimer}, 32'h0);
    check(32'(masterAllowed), 32'h0);
    $display("reset done");
    stop_test();
  end
endmodule
bind pcicfg_regs pcicfg_regs_monitor mon (
  .clk_sys(clk_sys), .reset_n(reset_n), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
  .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
  .cfgRdValid(cfgRdValid), .masterParityEvent(masterParityEvent),
  .targetAbortSeen(targetAbortSeen), .masterAbortSeen(masterAbortSeen),
  .specialCycle(specialCycle), .sysErrCondition(sysErrCondition),
  .parityErrSeen(parityErrSeen), .memAddrHit(memAddrHit), .ioAddrHit(ioAddrHit),
  .targetDone(targetDone), .deviceSelect_n(deviceSelect_n),
  .systemErrorOut_n(systemErrorOut_n), .systemErrorOutEn(systemErrorOutEn),
  .masterReadBurst(masterReadBurst), .latencyTimer(latencyTimer),
  .readMultiple(readMultiple), .masterAllowed(masterAllowed),
  .parityRespond(parityRespond));
